// ==== hw/rpso_top.sv ====
// Purpose: Reset generator, power switch enable, memory pin float control
// Assumes: supply_good and osc_running come from analog cells
// Notes:   Internal reset is the generated output itself
`timescale 1ns/1ps
`include "rpso_cfg.svh"
module rpso_top
	import rpso_pkg::*;
#(
	parameter int HOLD_CYCLES = `RPSO_HOLD_CYCLES,
	parameter int OSC_HALF    = `RPSO_OSC_HALF_CYCLES
) (
	input  wire logic ref_clk,
	input  wire logic rst_b,
	input  wire logic supply_good,
	input  wire logic osc_running,
	input  wire logic ext_clear_in_n,
	input  wire logic usb_configured,
	input  wire logic usb_suspended,
	input  wire logic usb_bus_reset,
	input  wire logic cfg_memory_select_core,
	input  wire logic cfg_memory_clock_core,
	input  wire logic cfg_memory_serial_core,
	input  wire logic cfg_memory_serial_core_oe,
	input  wire logic cfg_memory_serial_in,
	output logic      generated_clear_out_n,
	output logic      internal_clear_n,
	output logic      power_switch_on_n,
	output logic      cfg_memory_select,
	output logic      cfg_memory_select_oe,
	output logic      cfg_memory_clock,
	output logic      cfg_memory_clock_oe,
	output logic      cfg_memory_serial_io,
	output logic      cfg_memory_serial_io_oe,
	output logic      cfg_memory_serial_rd,
	output logic      oscillator_out
);
	// ----------------------------------------
	// Synchronised pin levels
	// ----------------------------------------
	rpso_sync_if sy ();
	logic [4:0] raw_lvl;
	logic [4:0] sync_lvl;

	// Supply and clock status combined into their own power_ok level: both gate start
	assign raw_lvl = {supply_good & osc_running, ext_clear_in_n,
		usb_configured, usb_suspended, usb_bus_reset};

	rpso_sync #(
		.WIDTH (5),
		.INIT  (5'h00)
	) u_sync (
		.ref_clk   (ref_clk),
		.rst_b     (rst_b),
		.raw_in    (raw_lvl),
		.clean_out (sync_lvl)
	);

	wire power_ok = sync_lvl[4];
	assign sy.ext_clear_n   = sync_lvl[3];
	assign sy.configured    = sync_lvl[2];
	assign sy.suspended     = sync_lvl[1];
	assign sy.usb_bus_reset = sync_lvl[0];

	// ----------------------------------------
	// Reset generator
	// ----------------------------------------
	localparam int CW = $clog2(HOLD_CYCLES + 1);
	rpso_state_type   state_r;
	rpso_state_type   state_nxt;
	logic [CW-1:0]    hold_cnt_r;
	logic [CW-1:0]    hold_cnt_nxt;
	logic             clear_n_r;

	// Bus reset deliberately not an input to this logic
	wire restart   = !power_ok || !sy.ext_clear_n;
	wire hold_done = (hold_cnt_r == CW'(HOLD_CYCLES - 1));

	always_comb begin
		state_nxt    = state_r;
		hold_cnt_nxt = hold_cnt_r;
		unique case (state_r)
			RPSO_HOLD: begin
				if (restart) begin
					hold_cnt_nxt = '0;
				end else if (hold_done) begin
					state_nxt = RPSO_RUN;
				end else begin
					hold_cnt_nxt = hold_cnt_r + CW'(1);
				end
			end
			RPSO_RUN: begin
				if (restart) begin
					state_nxt    = RPSO_HOLD;
					hold_cnt_nxt = '0;
				end
			end
			// Unused code: fall back to a fresh hold
			default: begin
				state_nxt    = RPSO_HOLD;
				hold_cnt_nxt = '0;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			state_r    <= RPSO_HOLD;
			hold_cnt_r <= '0;
			clear_n_r  <= `RPSO_CLEAR_RST;
		end else begin
			state_r    <= state_nxt;
			hold_cnt_r <= hold_cnt_nxt;
			clear_n_r  <= (state_nxt == RPSO_RUN);
		end
	end

	assign generated_clear_out_n = clear_n_r;
	assign internal_clear_n      = clear_n_r;

	// ----------------------------------------
	// Power switch and memory pins
	// ----------------------------------------
	logic pwr_r;
	logic sel_r;
	logic sel_oe_r;
	logic sck_r;
	logic sck_oe_r;
	logic sd_r;
	logic sd_oe_r;
	logic sd_in_r;

	// Any one cause turns the external switch off
	wire pwr_nxt   = !clear_n_r || sy.suspended || !sy.configured;
	// Pins float whole cycle where internal reset holds
	wire live      = clear_n_r && state_nxt == RPSO_RUN;
	wire sel_nxt   = live & cfg_memory_select_core;
	wire sck_nxt   = live & cfg_memory_clock_core;
	wire sd_nxt    = live & cfg_memory_serial_core;
	wire sd_oe_nxt = live & cfg_memory_serial_core_oe;

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			pwr_r <= `RPSO_PWR_RST;
		end else begin
			pwr_r <= pwr_nxt;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			sel_r    <= 1'b0;
			sel_oe_r <= 1'b0;
		end else begin
			sel_r    <= sel_nxt;
			sel_oe_r <= live;
		end
	end

	// Clock pin is driven from the cycle after reset is over
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			sck_r    <= 1'b0;
			sck_oe_r <= 1'b0;
		end else begin
			sck_r    <= sck_nxt;
			sck_oe_r <= live;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			sd_r    <= 1'b0;
			sd_oe_r <= 1'b0;
		end else begin
			sd_r    <= sd_nxt;
			sd_oe_r <= sd_oe_nxt;
		end
	end

	// Read path: one register, no filter; the core owns the timing
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			sd_in_r <= 1'b0;
		end else begin
			sd_in_r <= cfg_memory_serial_in;
		end
	end

	assign power_switch_on_n       = pwr_r;
	assign cfg_memory_select       = sel_r;
	assign cfg_memory_select_oe    = sel_oe_r;
	assign cfg_memory_clock        = sck_r;
	assign cfg_memory_clock_oe     = sck_oe_r;
	assign cfg_memory_serial_io    = sd_r;
	assign cfg_memory_serial_io_oe = sd_oe_r;
	assign cfg_memory_serial_rd    = sd_in_r;

	// ----------------------------------------
	// Oscillator output
	// ----------------------------------------
	localparam int OW = $clog2(OSC_HALF + 1);
	logic [OW-1:0] osc_cnt_r;
	logic          osc_r;
	wire osc_wrap = (osc_cnt_r == OW'(OSC_HALF - 1));

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			osc_cnt_r <= '0;
			osc_r     <= 1'b0;
		end else if (sy.suspended) begin
			osc_cnt_r <= osc_cnt_r;
			osc_r     <= osc_r;
		end else if (osc_wrap) begin
			osc_cnt_r <= '0;
			osc_r     <= !osc_r;
		end else begin
			osc_cnt_r <= osc_cnt_r + OW'(1);
		end
	end

	assign oscillator_out = osc_r;
endmodule : rpso_top

// ==== include/rpso_cfg.svh ====
// Purpose: Constants for the reset and power-state output block
// Assumes: ref_clk at 200 MHz
// Notes:   Times in their own units, cycle counts derived
// Function
// - After supply and clock up, hold reset output low fixed time, then high.
// - External active-low reset input low forces reset output low.
// - USB bus reset never touches the reset output.
// - Power switch enable low once configured and out of reset, high during suspend.
// - Memory pins float in reset; memory clock driven from one cycle after reset ends.
// - Oscillator output stops toggling while the link is suspended.
`ifndef RPSO_CFG_SVH
`define RPSO_CFG_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
// Nanosecond units keep the product inside a 32-bit int
`define RPSO_CLK_PERIOD_NS   5
`define RPSO_HOLD_TIME_US    5600
`define RPSO_HOLD_CYCLES     ((`RPSO_HOLD_TIME_US * 1000 + \
	`RPSO_CLK_PERIOD_NS - 1) / `RPSO_CLK_PERIOD_NS)
`define RPSO_OSC_HALF_CYCLES 16
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RPSO_CLEAR_RST       1'b0
`define RPSO_PWR_RST         1'b1
`endif

// ==== include/rpso_pkg.sv ====
// Purpose: Types for the reset and power-state output block
// Assumes: Nothing
// Notes:   Constants live in rpso_cfg.svh
package rpso_pkg;
	typedef enum logic [1:0] {
		RPSO_HOLD,
		RPSO_RUN
	} rpso_state_type;
endpackage : rpso_pkg

// ==== include/rpso_sync_if.sv ====
// Purpose: Synchronised pin levels passed to the top module
// Assumes: One clock domain
// Notes:   Filled in rpso_top from the synchroniser outputs
`timescale 1ns/1ps
interface rpso_sync_if;
	logic ext_clear_n;
	logic configured;
	logic suspended;
	logic usb_bus_reset;
	modport src (output ext_clear_n, output configured,
		output suspended, output usb_bus_reset);
	modport dst (input ext_clear_n, input configured,
		input suspended, input usb_bus_reset);
endinterface : rpso_sync_if

// ==== hw/rpso_sync.sv ====
// Purpose: Three-stage synchronisers for outside levels
// Assumes: Change accepted when stages two and three agree
// Notes:   Stage one feeds stage two only
`timescale 1ns/1ps
module rpso_sync
	import rpso_pkg::*;
#(
	parameter int WIDTH = 4,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input  wire logic             ref_clk,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] raw_in,
	output logic      [WIDTH-1:0] clean_out
);
	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;
	logic [WIDTH-1:0] clean_r;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			// Filter: hold until two late stages agree
			wire agree = (s2_r[i] == s3_r[i]);
			always_ff @(posedge ref_clk) begin
				if (!rst_b) begin
					s1_r[i]    <= INIT[i];
					s2_r[i]    <= INIT[i];
					s3_r[i]    <= INIT[i];
					clean_r[i] <= INIT[i];
				end else begin
					s1_r[i] <= raw_in[i];
					s2_r[i] <= s1_r[i];
					s3_r[i] <= s2_r[i];
					if (agree) begin
						clean_r[i] <= s3_r[i];
					end
				end
			end
		end
	endgenerate

	assign clean_out = clean_r;
endmodule : rpso_sync

// ==== test/rpso_mem_model.sv ====
// Purpose: Serial config memory beside the block
// Assumes: Pull-ups on released clock and data lines; a released select reads as deselected
// Notes:   Data bit flips on each memory clock
`timescale 1ns/1ps
module rpso_mem_model (
	input  wire logic cfg_memory_select,
	input  wire logic cfg_memory_select_oe,
	input  wire logic cfg_memory_clock,
	input  wire logic cfg_memory_clock_oe,
	input  wire logic cfg_memory_serial_io,
	input  wire logic cfg_memory_serial_io_oe,
	output logic      cfg_memory_serial_in
);
	logic bit_r = 1'b0;
	wire  sel_w = (cfg_memory_select_oe === 1'b1) && cfg_memory_select;
	wire  clk_w = (cfg_memory_clock_oe === 1'b1) ? cfg_memory_clock : 1'b1;
	always @(posedge clk_w) begin
		bit_r <= ~bit_r;
	end
	// Released data line reads as the pull-up level unless the memory is selected
	assign cfg_memory_serial_in = (cfg_memory_serial_io_oe === 1'b1) ?
		cfg_memory_serial_io : (sel_w ? bit_r : 1'b1);
endmodule : rpso_mem_model

// ==== test/rpso_top_sva.sv ====
// Purpose: Checks on reset and power outputs
// Assumes: Input sync latency below 8 cycles
// Notes:   Bound to rpso_top
`timescale 1ns/1ps
module rpso_top_sva #(
	parameter int HOLD_CYCLES = 20
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic supply_good,
	input wire logic osc_running,
	input wire logic ext_clear_in_n,
	input wire logic usb_configured,
	input wire logic usb_suspended,
	input wire logic generated_clear_out_n,
	input wire logic internal_clear_n,
	input wire logic power_switch_on_n,
	input wire logic cfg_memory_select_oe,
	input wire logic cfg_memory_clock_oe,
	input wire logic cfg_memory_serial_io_oe,
	input wire logic oscillator_out
);
	int  ok_cnt;
	wire up_ok = supply_good && osc_running && ext_clear_in_n;
	wire on_ok = usb_configured && !usb_suspended && generated_clear_out_n;
	wire any_oe = cfg_memory_select_oe || cfg_memory_clock_oe ||
		cfg_memory_serial_io_oe;
	always_ff @(posedge ref_clk) begin
		ok_cnt <= (!rst_b || !up_ok) ? 0 : ok_cnt + 1;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	a_hold_early: assert property (
		$rose(generated_clear_out_n) |-> ok_cnt >= HOLD_CYCLES)
		else $error("clear released early");
	a_hold_late: assert property (
		ok_cnt == HOLD_CYCLES + 10 |-> generated_clear_out_n)
		else $error("clear released late");
	a_ext_forces: assert property (
		!ext_clear_in_n [*8] |-> !generated_clear_out_n)
		else $error("external clear ignored");
	a_no_bus_clear: assert property (
		$fell(generated_clear_out_n) |-> ok_cnt < 8)
		else $error("clear without cause");
	a_switch_susp: assert property (
		usb_suspended [*8] |-> power_switch_on_n)
		else $error("switch on in suspend");
	a_switch_on: assert property (
		on_ok [*8] |-> !power_switch_on_n)
		else $error("switch off when configured");
	a_pins_float: assert property (
		!generated_clear_out_n |-> !any_oe)
		else $error("memory pin driven in reset");
	a_clock_driven: assert property (
		generated_clear_out_n [*2] |-> cfg_memory_clock_oe)
		else $error("memory clock not driven");
	a_osc_stop: assert property (
		usb_suspended [*8] |-> $stable(oscillator_out))
		else $error("oscillator runs in suspend");
	a_int_clear: assert property (
		internal_clear_n == generated_clear_out_n)
		else $error("internal clear differs");
	c_release: cover property ($rose(generated_clear_out_n));
	c_clear: cover property ($fell(generated_clear_out_n));
	c_switch: cover property ($fell(power_switch_on_n));
endmodule : rpso_top_sva
bind rpso_top rpso_top_sva #(.HOLD_CYCLES(HOLD_CYCLES)) u_sva (.*);

// ==== test/rpso_top_tb.sv ====
// Purpose: Self-checking bench for rpso_top
// Assumes: Hold count shortened to 20 cycles
// Notes:   Memory pins resolved by the memory model
`timescale 1ns/1ps
module rpso_top_tb;
	localparam int HOLD = 20;
	// No test-mode pin here: normal operation only
	logic ref_clk = 0, rst_b = 0, supply_good = 0, osc_running = 0;
	logic ext_clear_in_n = 1, usb_configured = 0, usb_suspended = 0;
	logic usb_bus_reset = 0, cfg_memory_select_core = 1;
	logic cfg_memory_clock_core = 0, cfg_memory_serial_core = 1;
	logic cfg_memory_serial_core_oe = 0, cfg_memory_serial_in;
	logic generated_clear_out_n, internal_clear_n, power_switch_on_n;
	logic cfg_memory_select, cfg_memory_select_oe, cfg_memory_clock;
	logic cfg_memory_clock_oe, cfg_memory_serial_io, oscillator_out;
	logic cfg_memory_serial_io_oe, cfg_memory_serial_rd, osc_s;
	int   miscompares = 0, n_checks = 0, n;
	rpso_top #(.HOLD_CYCLES(HOLD)) uut (.*);
	rpso_mem_model mem (.*);
	always #2.5 ref_clk = ~ref_clk;
	task step(input int c);
		repeat (c) @(posedge ref_clk);
		#1;
	endtask : step
	task chk(input string what, input logic seen, input logic exp);
		n_checks++;
		if (seen !== exp) begin
			$display("ERROR %s expected %b seen %b", what, exp, seen);
			miscompares++;
		end
	endtask : chk
	task finish_test;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test
	// Bounded wait; n counts cycles spent
	task wait_clear(input logic v);
		for (n = 0; generated_clear_out_n !== v; n++) begin
			if (n > HOLD + 20) begin
				miscompares++;
				finish_test;
			end
			step(1);
		end
	endtask : wait_clear
	task t_powerup;
		chk("mem_float", cfg_memory_serial_rd, 1'b1);
		chk("clk_oe_rst", cfg_memory_clock_oe, 1'b0);
		supply_good = 1;
		osc_running = 1;
		wait_clear(1);
		chk("hold_min", n >= HOLD, 1'b1);
		chk("internal", internal_clear_n, 1'b1);
		step(1);
		chk("clk_oe_run", cfg_memory_clock_oe, 1'b1);
		chk("sel_run", cfg_memory_select, 1'b1);
		step(1);
		chk("mem_rd0", cfg_memory_serial_rd, 1'b0);
		cfg_memory_clock_core = 1;
		step(2);
		chk("clk_run", cfg_memory_clock, 1'b1);
		chk("mem_rd1", cfg_memory_serial_rd, 1'b1);
		cfg_memory_serial_core_oe = 1;
		step(1);
		chk("io_run", cfg_memory_serial_io, 1'b1);
		chk("io_oe_run", cfg_memory_serial_io_oe, 1'b1);
		$display("t_powerup done");
	endtask : t_powerup
	task t_ext;
		ext_clear_in_n = 0;
		wait_clear(0);
		chk("int_low", internal_clear_n, 1'b0);
		chk("io_oe", cfg_memory_serial_io_oe, 1'b0);
		step(HOLD + 10);
		chk("held", generated_clear_out_n, 1'b0);
		ext_clear_in_n = 1;
		wait_clear(1);
		chk("rehold", n >= HOLD, 1'b1);
		usb_bus_reset = 1;
		step(30);
		chk("bus_rst", generated_clear_out_n, 1'b1);
		usb_bus_reset = 0;
		$display("t_ext done");
	endtask : t_ext
	task t_power;
		chk("pwr_unconf", power_switch_on_n, 1'b1);
		usb_configured = 1;
		step(8);
		chk("pwr_on", power_switch_on_n, 1'b0);
		usb_suspended = 1;
		step(8);
		chk("pwr_susp", power_switch_on_n, 1'b1);
		osc_s = oscillator_out;
		step(48);
		chk("osc_stop", oscillator_out, osc_s);
		usb_suspended = 0;
		for (n = 0; n < 40 && oscillator_out === osc_s; n++)
			step(1);
		chk("osc_run", n < 40, 1'b1);
		$display("t_power done");
	endtask : t_power
	initial begin
		step(3);
		rst_b = 1;
		step(2);
		t_powerup;
		t_ext;
		t_power;
		finish_test;
	end
endmodule : rpso_top_tb
